// ### core/hfc_cal_regs.sv
`timescale 1ns/100ps
module hfc_cal_regs (
    input  wire logic                       clk,
    input  wire logic                       srst,
    input  wire logic [7:0]                 reg_addr,
    input  wire logic [7:0]                 reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [7:0]                 reg_rdata,
    input  wire logic                       cal_done,
    input  wire logic [7:0]                 cal_bemf_level,
    input  wire logic [1:0]                 cal_amp_gain,
    output logic                            actuator_type_select,
    output logic      [2:0]                 brake_gain_ratio,
    output logic      [1:0]                 backemf_amp_gain,
    output logic      [7:0]                 drive_fb_gain,
    output logic      [hfc_pkg::BRAKE_W-1:0] brake_fb_gain,
    output logic      [hfc_pkg::UV_W-1:0]    backemf_uv
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0]                  level_r,  level_nxt;
    logic                        type_r,   type_nxt;
    logic [2:0]                  ratio_r,  ratio_nxt;
    logic [1:0]                  loop_r,   loop_nxt;
    logic [1:0]                  amp_r,    amp_nxt;
    logic [7:0]                  rdata_r,  rdata_nxt;
    logic [7:0]                  drive_r,  drive_nxt;
    logic [hfc_pkg::BRAKE_W-1:0] brake_r,  brake_nxt;
    logic [hfc_pkg::UV_W-1:0]    uv_r,     uv_nxt;
    logic [hfc_pkg::BRAKE_W-1:0] brake_calc;
    logic                        wr_level;
    logic                        wr_fb;

    function automatic logic [7:0] fb_image(input logic t, input logic [2:0] r,
                                            input logic [1:0] l, input logic [1:0] a);
        fb_image = {t, r, l, a};
    endfunction

    function automatic logic [hfc_pkg::UV_W-1:0] bemf_uv(input logic [7:0] code,
                                                         input logic [1:0] gain);
        logic [39:0] pct;
        logic [39:0] num;
        pct = hfc_pkg::AMP_PCT_0;
        case (gain)
            2'h0:    pct = hfc_pkg::AMP_PCT_0;
            2'h1:    pct = hfc_pkg::AMP_PCT_1;
            2'h2:    pct = hfc_pkg::AMP_PCT_2;
            default: pct = hfc_pkg::AMP_PCT_3;
        endcase
        num = {32'h0, code} * hfc_pkg::BEMF_FULL_UV * hfc_pkg::AMP_PCT_SCALE;
        bemf_uv = hfc_pkg::UV_W'(num / (hfc_pkg::BEMF_CODE_FS * pct));
    endfunction

    assign wr_level = reg_wr && (reg_addr == hfc_pkg::ADDR_CAL_BEMF);
    assign wr_fb    = reg_wr && (reg_addr == hfc_pkg::ADDR_FB_CTRL);

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    // calibration wins over a host write in the same cycle so a finished
    // measurement is never lost
    always_comb begin
        level_nxt = level_r;
        type_nxt  = type_r;
        ratio_nxt = ratio_r;
        loop_nxt  = loop_r;
        amp_nxt   = amp_r;
        if (wr_level) begin
            level_nxt = reg_wdata;
        end
        if (wr_fb) begin
            type_nxt  = reg_wdata[hfc_pkg::TYPE_BIT];
            ratio_nxt = reg_wdata[hfc_pkg::RATIO_MSB:hfc_pkg::RATIO_LSB];
            loop_nxt  = reg_wdata[hfc_pkg::LOOP_MSB:hfc_pkg::LOOP_LSB];
            amp_nxt   = reg_wdata[hfc_pkg::AMP_MSB:hfc_pkg::AMP_LSB];
        end
        if (cal_done) begin
            level_nxt = cal_bemf_level;
            amp_nxt   = cal_amp_gain;
        end
    end

    always_comb begin
        rdata_nxt = rdata_r;
        if (reg_rd) begin
            case (reg_addr)
                hfc_pkg::ADDR_CAL_BEMF: rdata_nxt = level_r;
                hfc_pkg::ADDR_FB_CTRL:  rdata_nxt = fb_image(type_r, ratio_r, loop_r, amp_r);
                default:                rdata_nxt = hfc_pkg::RDATA_UNMAPPED;
            endcase
        end
    end

    // ------------------------------------------------------------
    // playback engine controls
    // ------------------------------------------------------------
    hfc_gain_scale u_gain_scale (
        .drive_gain       (level_r),
        .brake_gain_ratio (ratio_r),
        .brake_gain       (brake_calc)
    );

    // gains and voltage trail the stored values by one cycle, so the
    // wide divide never sits on the register write path
    always_comb begin
        drive_nxt = level_r;
        brake_nxt = brake_calc;
        uv_nxt    = bemf_uv(level_r, amp_r);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            level_r <= hfc_pkg::RST_CAL_BEMF;
            type_r  <= hfc_pkg::RST_TYPE;
            ratio_r <= hfc_pkg::RST_RATIO;
            loop_r  <= hfc_pkg::RST_FB_CTRL[hfc_pkg::LOOP_MSB:hfc_pkg::LOOP_LSB];
            amp_r   <= hfc_pkg::RST_AMP;
            rdata_r <= hfc_pkg::RDATA_UNMAPPED;
            drive_r <= 8'h00;
            brake_r <= 13'h0000;
            uv_r    <= 22'h000000;
        end else begin
            level_r <= level_nxt;
            type_r  <= type_nxt;
            ratio_r <= ratio_nxt;
            loop_r  <= loop_nxt;
            amp_r   <= amp_nxt;
            rdata_r <= rdata_nxt;
            drive_r <= drive_nxt;
            brake_r <= brake_nxt;
            uv_r    <= uv_nxt;
        end
    end

    assign reg_rdata            = rdata_r;
    assign actuator_type_select = type_r;
    assign brake_gain_ratio     = ratio_r;
    assign backemf_amp_gain     = amp_r;
    assign drive_fb_gain        = drive_r;
    assign brake_fb_gain        = brake_r;
    assign backemf_uv           = uv_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // the release edge still samples the pre-reset state, so checks that
    // look one cycle back skip any attempt that starts with srst high
    sequence s_cal_finish;
        cal_done;
    endsequence

    sequence s_host_level_write;
        wr_level && !cal_done;
    endsequence

    chk_level_reset: assert property (@(posedge clk)
        srst |=> level_r == hfc_pkg::RST_CAL_BEMF)
        else $error("calibration level not 0x6D after reset");

    chk_cal_capture: assert property (@(posedge clk) disable iff (srst)
        s_cal_finish |=> level_r == $past(cal_bemf_level))
        else $error("calibration result not stored");

    chk_host_override: assert property (@(posedge clk) disable iff (srst)
        s_host_level_write |=> level_r == $past(reg_wdata))
        else $error("host write to level lost");

    chk_level_hold: assert property (@(posedge clk) disable iff (srst)
        !srst && !wr_level && !cal_done |=> $stable(level_r))
        else $error("level changed without cause");

    chk_drive_gain: assert property (@(posedge clk) disable iff (srst)
        s_cal_finish ##1 1'b1 |=> drive_fb_gain == $past(cal_bemf_level, 2))
        else $error("drive gain does not follow level");

    chk_type_write: assert property (@(posedge clk) disable iff (srst)
        wr_fb |=> actuator_type_select == $past(reg_wdata[7]))
        else $error("actuator type not written");

    chk_ratio_write: assert property (@(posedge clk) disable iff (srst)
        wr_fb |=> brake_gain_ratio == $past(reg_wdata[6:4]))
        else $error("brake ratio not written");

    chk_brake_scale: assert property (@(posedge clk) disable iff (srst)
        !srst && ratio_r == 3'h5 |=> brake_fb_gain == {$past(level_r), 3'h0})
        else $error("brake gain not eight times drive gain");

    chk_brake_ge: assert property (@(posedge clk) disable iff (srst)
        !srst && ratio_r != 3'h7 |=> brake_fb_gain >= {5'h00, drive_fb_gain})
        else $error("brake gain below drive gain");

    chk_amp_cal: assert property (@(posedge clk) disable iff (srst)
        s_cal_finish |=> backemf_amp_gain == $past(cal_amp_gain))
        else $error("amp gain not filled by calibration");

    chk_volt_full: assert property (@(posedge clk) disable iff (srst)
        !srst && level_r == 8'hFF && amp_r == 2'h1 |=> backemf_uv == 22'h129DA0)
        else $error("full-scale voltage not 1.22 V");

    chk_read_level: assert property (@(posedge clk) disable iff (srst)
        reg_rd && reg_addr == hfc_pkg::ADDR_CAL_BEMF |=> reg_rdata == $past(level_r))
        else $error("level readback wrong");

    chk_amp_write: assert property (@(posedge clk) disable iff (srst)
        wr_fb && !cal_done |=> backemf_amp_gain == $past(reg_wdata[1:0]))
        else $error("amp gain not written");

    chk_read_fb: assert property (@(posedge clk) disable iff (srst)
        reg_rd && reg_addr == hfc_pkg::ADDR_FB_CTRL |=>
            reg_rdata == {$past(type_r), $past(ratio_r), $past(loop_r), $past(amp_r)})
        else $error("feedback control readback wrong");
endmodule // hfc_cal_regs

// ### core/hfc_gain_scale.sv
`timescale 1ns/100ps
module hfc_gain_scale (
    input  wire logic [7:0]                 drive_gain,
    input  wire logic [2:0]                 brake_gain_ratio,
    output logic      [hfc_pkg::BRAKE_W-1:0] brake_gain
);
    logic [4:0] mult;

    // code 6 doubles the top ratio; code 7 stops braking altogether
    always_comb begin
        case (brake_gain_ratio)
            3'h0:    mult = 5'h01;
            3'h1:    mult = 5'h02;
            3'h2:    mult = 5'h03;
            3'h3:    mult = 5'h04;
            3'h4:    mult = 5'h06;
            3'h5:    mult = 5'h08;
            3'h6:    mult = 5'h10;
            default: mult = 5'h00;
        endcase
        brake_gain = 13'(drive_gain * mult);
    end
endmodule // hfc_gain_scale

// ### core/hfc_pkg.sv
package hfc_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CAL_BEMF  = 8'h19;
    localparam logic [7:0] ADDR_FB_CTRL   = 8'h1A;
    localparam logic [7:0] RST_CAL_BEMF   = 8'h6D;
    localparam logic [7:0] RST_FB_CTRL    = 8'h36;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

    // ------------------------------------------------------------
    // feedback control fields
    // ------------------------------------------------------------
    localparam int TYPE_BIT       = 7;
    localparam int RATIO_MSB      = 6;
    localparam int RATIO_LSB      = 4;
    localparam int LOOP_MSB       = 3;
    localparam int LOOP_LSB       = 2;
    localparam int AMP_MSB        = 1;
    localparam int AMP_LSB        = 0;
    localparam logic RST_TYPE     = 1'b0;
    localparam logic [2:0] RST_RATIO = 3'h3;
    localparam logic [1:0] RST_AMP   = 2'h2;

    typedef enum logic {
        HFC_ROTATING_MASS_MODE   = 1'b0,
        HFC_LINEAR_RESONANT_MODE = 1'b1
    } hfc_actuator_t;

    // ------------------------------------------------------------
    // back-emf scaling
    // ------------------------------------------------------------
    localparam logic [39:0] BEMF_FULL_UV = 40'h0000129DA0; // 1.22 V in uV
    localparam logic [39:0] BEMF_CODE_FS = 40'h00000000FF; // 255
    localparam logic [39:0] AMP_PCT_SCALE = 40'h0000000064; // gains held x100
    localparam logic [39:0] AMP_PCT_0 = 40'h0000000021; // 0.33x
    localparam logic [39:0] AMP_PCT_1 = 40'h0000000064; // 1.0x
    localparam logic [39:0] AMP_PCT_2 = 40'h00000000B4; // 1.8x
    localparam logic [39:0] AMP_PCT_3 = 40'h0000000190; // 4.0x
    localparam int UV_W     = 22;
    localparam int BRAKE_W  = 13;
    localparam logic [2:0] RATIO_DISABLED = 3'h7;
endpackage

// ### tb/hfc_cal_regs_tb_top.sv
`timescale 1ns/100ps
module hfc_cal_regs_tb_top;
    localparam logic [7:0] AL = hfc_pkg::ADDR_CAL_BEMF;
    localparam logic [7:0] AF = hfc_pkg::ADDR_FB_CTRL;
    localparam int MULT [8] = '{1, 2, 3, 4, 6, 8, 16, 0};
    localparam logic [39:0] PCT [4] = '{hfc_pkg::AMP_PCT_0, hfc_pkg::AMP_PCT_1,
                                        hfc_pkg::AMP_PCT_2, hfc_pkg::AMP_PCT_3};
    logic        clk, srst = 1'b1, reg_wr, reg_rd, cal_done, actuator_type_select;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, cal_bemf_level, drive_fb_gain, lvl;
    logic [1:0]  cal_amp_gain, backemf_amp_gain, amp;
    logic [2:0]  brake_gain_ratio, rc;
    logic [12:0] brake_fb_gain;
    logic [21:0] backemf_uv;
    logic [39:0] uv_exp;
    logic        tsel, rd_seen = 1'b0;
    int          n_fail = 0, tests_run = 0, cyc = 0, seed = 32'h2083;
    hfc_cal_regs hfc_cal_regs_i (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .cal_done, .cal_bemf_level, .cal_amp_gain, .actuator_type_select,
        .brake_gain_ratio, .backemf_amp_gain, .drive_fb_gain, .brake_fb_gain, .backemf_uv);
    hfc_host_model hfc_host_model_i (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .cal_done, .cal_bemf_level, .cal_amp_gain);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ------------------------------------------------------------
    // checking
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [39:0] seen, input logic [39:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        rd_seen <= reg_rd;
        if (cyc == 2000) begin
            n_fail++;
            conclude();
        end
    end
    // read data stands from the edge after the taken read
    always @(negedge clk) if (rd_seen) begin
        check("reg_rdata", reg_rdata, hfc_host_model_i.exp_q.pop_front());
    end
    task automatic op(input logic w, input logic r, input logic [7:0] a,
                      input logic [7:0] d, input logic [7:0] e);
        hfc_host_model_i.op(w, r, a, d, e);
    endtask
    // derived outputs lag the registers by one edge
    task automatic settle();
        op(1'b0, 1'b0, AL, 8'h00, 8'h00);
        op(1'b0, 1'b0, AL, 8'h00, 8'h00);
        #1;
    endtask
    task automatic do_reset(input int n);
        @(posedge clk);
        srst <= 1'b1;
        repeat (n) @(posedge clk);
        srst <= 1'b0;
    endtask
    task automatic chk_defaults();
        settle();
        check("type", actuator_type_select, 1'b0);
        check("ratio", brake_gain_ratio, 3'h3);
        check("amp", backemf_amp_gain, 2'h2);
        check("drive", drive_fb_gain, 8'h6D);
        check("brake", brake_fb_gain, 13'h01B4);
        op(1'b0, 1'b1, AL, 8'h00, 8'h6D);
        op(1'b0, 1'b1, AF, 8'h00, 8'h36);
        op(1'b0, 1'b1, 8'h1B, 8'h00, 8'h00);
        $display("defaults test done");
    endtask
    initial begin
        do_reset(6);
        chk_defaults();
        for (int i = 0; i < 8; i++) begin
            rc = 3'(i);
            tsel = 1'($random(seed));
            amp = 2'($random(seed));
            op(1'b1, 1'b0, AF, {tsel, rc, 2'h1, amp}, 8'h00);
            settle();
            check("type", actuator_type_select, tsel);
            check("ratio", brake_gain_ratio, rc);
            check("amp", backemf_amp_gain, amp);
            check("brake", brake_fb_gain, 40'h6D * MULT[i]);
            op(1'b0, 1'b1, AF, 8'h00, {tsel, rc, 2'h1, amp});
        end
        $display("ratio test done");
        for (int i = 0; i < 6; i++) begin
            lvl = (i == 1) ? 8'hFF : 8'($random(seed));
            amp = 2'(i);
            hfc_host_model_i.cal_arm(lvl, amp);
            // odd passes collide a host write with calibration, which must win
            op(i[0], 1'b0, AL, 8'h00, 8'h00);
            settle();
            uv_exp = (40'(lvl) * hfc_pkg::BEMF_FULL_UV * hfc_pkg::AMP_PCT_SCALE)
                     / (hfc_pkg::BEMF_CODE_FS * PCT[amp]);
            check("drive", drive_fb_gain, lvl);
            check("amp", backemf_amp_gain, amp);
            check("uv", 40'(backemf_uv) - uv_exp + 40'h1 <= 40'h2, 1'b1);
            op(1'b0, 1'b1, AL, 8'h00, lvl);
        end
        $display("calibration test done");
        lvl = 8'($random(seed));
        op(1'b1, 1'b0, AL, lvl, 8'h00);
        op(1'b1, 1'b1, AL, ~lvl, lvl);
        op(1'b1, 1'b0, 8'h18, 8'hFF, 8'h00);
        op(1'b0, 1'b1, AL, 8'h00, ~lvl);
        settle();
        check("drive", drive_fb_gain, 8'(~lvl));
        $display("host write test done");
        do_reset(1);
        chk_defaults();
        settle();
        conclude();
    end
endmodule // hfc_cal_regs_tb_top

// ### tb/hfc_host_model.sv
`timescale 1ns/100ps
module hfc_host_model (
    input  wire logic       clk,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic            cal_done,
    output logic      [7:0] cal_bemf_level,
    output logic      [1:0] cal_amp_gain
);
    logic [7:0] exp_q[$];
    logic       pend = 1'b0;
    logic       fb_set = 1'b0;
    logic [7:0] p_lvl;
    logic [1:0] p_gain;
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h00000;
        {cal_done, cal_bemf_level, cal_amp_gain} = 11'h000;
    end
    // ------------------------------------------------------------
    // bus cycles
    // ------------------------------------------------------------
    // calibration only after type and ratio are programmed
    task automatic cal_arm(input logic [7:0] l, input logic [1:0] g);
        if (fb_set) begin
            p_lvl = l;
            p_gain = g;
            pend = 1'b1;
        end
    endtask
    // one cycle per call; back to back calls give back to back strobes
    task automatic op(input logic w, input logic r, input logic [7:0] a,
                      input logic [7:0] d, input logic [7:0] e);
        @(posedge clk);
        if (r) exp_q.push_back(e);
        if (w && a == hfc_pkg::ADDR_FB_CTRL) fb_set = 1'b1;
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        // released lines never keep the last value
        reg_wdata <= w ? d : ~reg_wdata;
        cal_done <= pend;
        cal_bemf_level <= pend ? p_lvl : ~cal_bemf_level;
        cal_amp_gain <= pend ? p_gain : ~cal_amp_gain;
        pend = 1'b0;
    endtask
endmodule // hfc_host_model
